//--- src/lmc_mode_ctrl.sv
// mode controller of a single-wire lin transceiver
////////////////////////////////////////////////////////////////////////////////
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int unsigned ACT_CYC   = ACT_DEBOUNCE_CYC,
  parameter int unsigned TXD_CYC   = TXD_TIMEOUT_CYC,
  parameter int unsigned BUS_CYC   = BUS_TIMEOUT_CYC,
  parameter int unsigned FVAL_CYC  = FAULT_VALID_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // host side pins (asynchronous)
  input  wire logic chip_select_in,
  input  wire logic tx_data_in,
  input  wire logic wake_in,
  output logic      rx_data_out,
  // fault / transmit-enable open-drain pin
  input  wire logic fault_txen_in,
  output logic      fault_txen_out,
  output logic      fault_txen_oe,
  // lin bus open-drain pin
  input  wire logic bus_line_in,
  output logic      bus_line_out,
  output logic      bus_line_oe,
  // analog monitors (asynchronous)
  input  wire logic thermal_overload,
  input  wire logic temp_recovered,
  input  wire logic supply_stable,
  // mode outputs
  output logic      tx_enable,
  output logic      rx_enable,
  output logic      regulator_enable,
  output logic [2:0] mode_state
);

  localparam int CW = 32;

  // a zero count would make a timer fire at once
  if (ACT_CYC < 1 || TXD_CYC < 2 || BUS_CYC < 2 || FVAL_CYC < 1) begin : g_bad_timing
    $error("lmc_mode_ctrl: timing counts too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one is read only by stage two
  lmc_pins_t raw, s1_q, sy_q, sy_prev_q;
  assign raw = '{cs: chip_select_in, txd: tx_data_in, wake: wake_in, bus: bus_line_in,
                 ftx: fault_txen_in, therm: thermal_overload, trec: temp_recovered,
                 sup_ok: supply_stable};

  always_ff @(posedge mclk) begin
    if (rst) begin
      // idle levels, so that no false edge follows reset
      s1_q      <= PINS_IDLE;
      sy_q      <= PINS_IDLE;
      sy_prev_q <= PINS_IDLE;
    end else begin
      s1_q      <= raw;
      sy_q      <= s1_q;
      sy_prev_q <= sy_q;
    end
  end

  logic cs_rise, cs_fall, wake_fall, txd_rise, txd_fall;
  assign cs_rise   = sy_q.cs & ~sy_prev_q.cs;
  assign cs_fall   = ~sy_q.cs & sy_prev_q.cs;
  assign wake_fall = ~sy_q.wake & sy_prev_q.wake;
  assign txd_rise  = sy_q.txd & ~sy_prev_q.txd;
  assign txd_fall  = ~sy_q.txd & sy_prev_q.txd;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  logic [CW-1:0] act_cnt_q, txd_cnt_q, bus_cnt_q, fval_cnt_q;
  logic          bus_active, txd_expired, bus_expired, fval_ok;

  assign bus_active  = act_cnt_q >= CW'(ACT_CYC);
  assign txd_expired = txd_cnt_q >= CW'(TXD_CYC);
  assign bus_expired = bus_cnt_q >= CW'(BUS_CYC);
  assign fval_ok     = fval_cnt_q >= CW'(FVAL_CYC);

  always_ff @(posedge mclk) begin
    if (rst || sy_q.bus)
      act_cnt_q <= '0;
    else if (!bus_active)
      act_cnt_q <= act_cnt_q + CW'(1);
  end

  // transmit timeout counts only while the host drives dominant; latched until rising edge
  logic txd_to_q;
  always_ff @(posedge mclk) begin
    if (rst || sy_q.txd)
      txd_cnt_q <= '0;
    else if (!txd_expired)
      txd_cnt_q <= txd_cnt_q + CW'(1);
  end
  always_ff @(posedge mclk) begin
    if (rst || txd_rise)
      txd_to_q <= 1'b0;
    else if (txd_expired)
      txd_to_q <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst || sy_q.bus)
      bus_cnt_q <= '0;
    else if (!bus_expired)
      bus_cnt_q <= bus_cnt_q + CW'(1);
  end

  always_ff @(posedge mclk) begin
    if (rst || txd_fall || sy_q.txd)
      fval_cnt_q <= '0;
    else if (!fval_ok)
      fval_cnt_q <= fval_cnt_q + CW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // faults
  logic therm_q, contention, short_vbb, any_fault;
  always_ff @(posedge mclk) begin
    if (rst)
      therm_q <= 1'b0;
    else if (sy_q.therm)
      therm_q <= 1'b1;  // set wins over recovery
    else if (sy_q.trec)
      therm_q <= 1'b0;
  end

  // we send recessive but the bus stays dominant for the whole bus timeout
  assign contention = sy_q.txd & ~sy_q.bus & bus_expired;
  // we drive dominant yet the bus reads recessive once the report delay is over
  assign short_vbb  = tx_enable & ~sy_q.txd & sy_q.bus & fval_ok;
  assign any_fault  = therm_q | contention | short_vbb | txd_to_q | bus_expired;

  // host override: pin low while this side is not pulling it
  logic ext_off;
  assign ext_off = ~sy_q.ftx & ~fault_txen_oe;

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  lmc_state_t state_q, state_d;
  logic       wake_pend_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POR: begin
        if (sy_q.sup_ok)
          state_d = sy_q.cs ? ST_OPER : ST_READY;
      end
      ST_READY: begin
        if (wake_pend_q && sy_q.cs && sy_q.sup_ok)
          state_d = ST_OPER;
        else if (cs_rise)
          state_d = sy_q.txd ? ST_OPER : ST_TXOFF;
      end
      ST_OPER: begin
        if (cs_fall)
          state_d = ST_PDOWN;
        else if (any_fault || ext_off)
          state_d = ST_TXOFF;
      end
      ST_PDOWN: begin
        if (bus_active || sy_q.cs || wake_fall)
          state_d = ST_READY;
      end
      ST_TXOFF: begin
        if (cs_fall)
          state_d = ST_PDOWN;
        else if (!any_fault && sy_q.ftx && sy_q.txd && sy_q.cs)
          state_d = ST_OPER;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst)
      state_q <= ST_POR;
    else
      state_q <= state_d;
  end

  // marks a ready stay that began by waking from power-down
  always_ff @(posedge mclk) begin
    if (rst)
      wake_pend_q <= 1'b0;
    else if (state_q == ST_PDOWN && state_d == ST_READY)
      wake_pend_q <= 1'b1;
    else if (state_q != ST_READY || !sy_q.cs)
      wake_pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  lmc_en_t en_d;
  logic    txd_int;
  assign en_d    = lmc_mode_en(state_d);
  // a disabled transmitter sees recessive data whatever the pin says
  assign txd_int = (en_d.tx_en && sy_q.ftx) ? sy_q.txd : 1'b1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_enable        <= 1'b0;
      rx_enable        <= 1'b0;
      regulator_enable <= 1'b0;
      mode_state       <= 3'h0;
      bus_line_out     <= 1'b0;
      bus_line_oe      <= 1'b0;
      fault_txen_out   <= 1'b0;
      fault_txen_oe    <= 1'b0;
      rx_data_out      <= 1'b1;
    end else begin
      tx_enable        <= en_d.tx_en;
      rx_enable        <= en_d.rx_en;
      regulator_enable <= en_d.reg_en;
      mode_state       <= 3'(state_d);
      bus_line_out     <= 1'b0;
      bus_line_oe      <= ~txd_int;
      fault_txen_out   <= 1'b0;
      fault_txen_oe    <= therm_q | contention | short_vbb;
      rx_data_out      <= sy_q.bus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence cs_drop_s;
    sy_q.cs ##1 !sy_q.cs;
  endsequence

  sequence wake_ready_s;
    state_q == ST_PDOWN ##1 (state_q == ST_READY && wake_pend_q);
  endsequence

  pd_outputs_off_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_PDOWN |-> (!tx_enable && !regulator_enable)) else $error("pd enables on");
  pd_wake_exit_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_PDOWN && sy_q.cs) |=> state_q == ST_READY) else $error("pd no wake");
  bus_debounce_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_PDOWN && $rose(bus_active)) |-> !$past(sy_q.bus))
    else $error("bad bus act");
  ready_enables_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_READY |=> (state_q != ST_READY || (rx_enable && !tx_enable)))
    else $error("ready enables wrong");
  ready_txd_low_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_READY && !wake_pend_q && cs_rise && !sy_q.txd) |=> state_q == ST_TXOFF)
    else $error("ready not txoff");
  oper_cs_fall_a: assert property (@(posedge mclk) disable iff (rst)
    cs_drop_s ##0 (state_q == ST_OPER) |=> state_q == ST_PDOWN) else $error("no pd");
  oper_fault_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_OPER && !cs_fall && therm_q) |=> state_q == ST_TXOFF) else $error("fault");
  reg_enable_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 (regulator_enable == ($past(state_d) != ST_PDOWN && $past(state_d) != ST_POR)))
    else $error("regulator enable wrong");
  rx_mirror_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 rx_data_out == $past(sy_q.bus)) else $error("rx not mirrored");
  tx_forced_a: assert property (@(posedge mclk) disable iff (rst)
    !tx_enable |-> !bus_line_oe) else $error("bus driven while disabled");
  ready_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_READY && !sy_q.cs) |=> state_q == ST_READY)
    else $error("ready left with select low");
  wake_oper_a: assert property (@(posedge mclk) disable iff (rst)
    wake_ready_s ##0 (sy_q.cs && sy_q.sup_ok) |=> state_q == ST_OPER)
    else $error("wake with select high did not reach operation");
  txoff_cs_fall_a: assert property (@(posedge mclk) disable iff (rst)
    cs_drop_s ##0 (state_q == ST_TXOFF) |=> state_q == ST_PDOWN)
    else $error("transmitter off did not power down");
  txoff_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_TXOFF && (!sy_q.ftx || !sy_q.txd || any_fault)) |=> state_q != ST_OPER)
    else $error("operation resumed too early");
  por_outputs_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == ST_POR |-> (!tx_enable && !rx_enable && !regulator_enable))
    else $error("enables on in reset state");
  therm_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (therm_q && !sy_q.therm && sy_q.trec) |=> !therm_q)
    else $error("thermal fault did not clear");
  txd_timeout_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_OPER && txd_to_q && !cs_fall) |=> state_q == ST_TXOFF)
    else $error("transmit timeout ignored");
  bus_timeout_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_OPER && bus_expired && !cs_fall) |=> state_q == ST_TXOFF)
    else $error("bus dominant timeout ignored");
  ftx_low_a: assert property (@(posedge mclk) disable iff (rst)
    !sy_q.ftx |=> !bus_line_oe)
    else $error("bus driven while enable pin low");
  bus_clear_a: assert property (@(posedge mclk) disable iff (rst)
    sy_q.bus |=> !bus_active)
    else $error("activity kept over recessive bus");

endmodule

//--- src/lmc_pkg.sv
// package: state encoding, pin bundles and timing constants for the lin mode controller
package lmc_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  // activity debounce, minimum time, in ns
  localparam int unsigned ACT_DEBOUNCE_NS  = 30000;
  localparam int unsigned ACT_DEBOUNCE_CYC = (ACT_DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  // transmit dominant timeout, in ms
  localparam int unsigned TXD_TIMEOUT_MS   = 10;
  localparam int unsigned TXD_TIMEOUT_CYC  = TXD_TIMEOUT_MS * CLK_MHZ * 1000;
  // bus dominant timeout, in ms
  localparam int unsigned BUS_TIMEOUT_MS   = 25;
  localparam int unsigned BUS_TIMEOUT_CYC  = BUS_TIMEOUT_MS * CLK_MHZ * 1000;
  // fault report delay after a transmit falling edge, in ns
  localparam int unsigned FAULT_VALID_NS   = 25000;
  localparam int unsigned FAULT_VALID_CYC  = (FAULT_VALID_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_POR,
    ST_READY,
    ST_OPER,
    ST_PDOWN,
    ST_TXOFF
  } lmc_state_t;

  // enables derived from the mode
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic reg_en;
  } lmc_en_t;

  // synchronised pin levels
  typedef struct packed {
    logic cs;
    logic txd;
    logic wake;
    logic bus;
    logic ftx;
    logic therm;
    logic trec;
    logic sup_ok;
  } lmc_pins_t;

  // pin levels the synchronisers hold in reset: select low, every other wire at rest
  localparam lmc_pins_t PINS_IDLE = '{cs: 1'b0, txd: 1'b1, wake: 1'b1, bus: 1'b1, ftx: 1'b1,
                                      therm: 1'b0, trec: 1'b0, sup_ok: 1'b0};

  function automatic lmc_en_t lmc_mode_en(input lmc_state_t s);
    lmc_en_t e;
    e = '0;
    unique case (s)
      ST_POR:   e = '0;
      ST_READY: e = '{tx_en: 1'b0, rx_en: 1'b1, reg_en: 1'b1};
      ST_OPER:  e = '{tx_en: 1'b1, rx_en: 1'b1, reg_en: 1'b1};
      ST_PDOWN: e = '{tx_en: 1'b0, rx_en: 1'b0, reg_en: 1'b0};
      ST_TXOFF: e = '{tx_en: 1'b0, rx_en: 1'b1, reg_en: 1'b1};
    endcase
    return e;
  endfunction

endpackage

//--- test/lmc_far_model.sv
// far side model: lin bus wire and fault/transmit-enable wire, both with pull-ups
////////////////////////////////////////////////////////////////////////////////
module lmc_far_model (
  // device side drives
  input  wire logic bus_line_oe,
  input  wire logic fault_txen_oe,
  // bench commands
  input  wire logic ext_dom,
  input  wire logic host_ftx_low,
  input  wire logic host_cs,
  input  wire logic host_cs_rel,
  input  wire logic ext_sw,
  // resolved wire levels
  output logic      bus_line_in,
  output logic      fault_txen_in,
  output logic      chip_select_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released wires return to the pull-up level, never the last driven level
  assign bus_line_in   = ~(bus_line_oe | ext_dom);
  // either party pulling low disables the transmitter
  assign fault_txen_in = ~(fault_txen_oe | host_ftx_low);
  // a released select line rests at its pull-down unless an outside switch raises it
  assign chip_select_in = host_cs_rel ? ext_sw : host_cs;
endmodule

//--- test/tb_lin_transceiver_mode_control.sv
// self-checking bench for the lin mode controller
////////////////////////////////////////////////////////////////////////////////
module tb_lin_transceiver_mode_control;
  import lmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run brief
  localparam int ACT = 8;
  localparam int TXD = 40;
  localparam int BUS = 60;
  logic       mclk, rst, cs, txd, wake, rxd, ftx_in, ftx_oe, bus_in, bus_oe;
  logic       therm, trec, sup, tx_en, rx_en, reg_en, ext_dom, host_ftx;
  logic       cs_pin, cs_rel, ext_sw, ftx_out, bus_out;
  logic [2:0] mode;
  int         bad_count, checked;

  lmc_mode_ctrl #(.ACT_CYC(ACT), .TXD_CYC(TXD), .BUS_CYC(BUS), .FVAL_CYC(4)) dut_u (
    .mclk(mclk), .rst(rst), .chip_select_in(cs_pin), .tx_data_in(txd), .wake_in(wake),
    .rx_data_out(rxd), .fault_txen_in(ftx_in), .fault_txen_out(ftx_out),
    .fault_txen_oe(ftx_oe), .bus_line_in(bus_in), .bus_line_out(bus_out), .bus_line_oe(bus_oe),
    .thermal_overload(therm), .temp_recovered(trec), .supply_stable(sup),
    .tx_enable(tx_en), .rx_enable(rx_en), .regulator_enable(reg_en), .mode_state(mode));

  lmc_far_model far_u (
    .bus_line_oe(bus_oe), .fault_txen_oe(ftx_oe), .ext_dom(ext_dom),
    .host_ftx_low(host_ftx), .host_cs(cs), .host_cs_rel(cs_rel), .ext_sw(ext_sw),
    .bus_line_in(bus_in), .fault_txen_in(ftx_in), .chip_select_in(cs_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask

  // expected enables {tx, rx, reg} per mode
  function automatic logic [2:0] en_of(lmc_state_t m);
    case (m)
      ST_OPER:            return 3'h7;
      ST_READY, ST_TXOFF: return 3'h3;
      default:            return 3'h0;
    endcase
  endfunction

  // bounded wait for a mode, then mode and enables are compared
  task automatic wait_mode(lmc_state_t m, int bound);
    int i;
    for (i = 0; i < bound && mode !== 3'(m); i++) cyc(1);
    check(8'(mode), 8'(m));
    check({5'h0, tx_en, rx_en, reg_en}, {5'h0, en_of(m)});
    if (i >= bound) give_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(6);
    check({5'h0, mode}, 8'h00);
    check({5'h0, tx_en, rx_en, reg_en}, 8'h00);
    rst = 1'b0;
    wait_mode(ST_READY, 20);
    cyc(10);
    check({4'h0, mode, bus_oe}, {4'h0, 3'(ST_READY), 1'b0});
    $display("test reset done");
  endtask

  task automatic t_select();
    cs = 1'b1;
    wait_mode(ST_OPER, 10);
    txd = 1'b0;
    cyc(8);
    check({6'h0, bus_oe, rxd}, 8'h02);
    txd = 1'b1;
    cyc(8);
    check({7'h0, rxd}, 8'h01);
    ext_dom = 1'b1;
    cyc(6);
    check({7'h0, rxd}, 8'h00);
    ext_dom = 1'b0;
    cs = 1'b0;
    wait_mode(ST_PDOWN, 10);
    check({7'h0, bus_oe}, 8'h00);
    $display("test select done");
  endtask

  task automatic t_wake();
    wake = 1'b0;
    wait_mode(ST_READY, 10);
    wake = 1'b1;
    txd = 1'b0;
    cs = 1'b1;
    wait_mode(ST_TXOFF, 10);
    cyc(3);
    check({7'h0, bus_oe}, 8'h00);
    cs = 1'b0;
    wait_mode(ST_PDOWN, 10);
    txd = 1'b1;
    $display("test wake done");
  endtask

  task automatic t_local_wake();
    cs_rel = 1'b1;
    cs = 1'b1;
    cyc(6);
    check({5'h0, mode}, 8'(ST_PDOWN));
    ext_sw = 1'b1;
    wait_mode(ST_OPER, 20);
    ext_sw = 1'b0;
    wait_mode(ST_PDOWN, 10);
    cs = 1'b0;
    cs_rel = 1'b0;
    $display("test local wake done");
  endtask

  task automatic t_activity();
    ext_dom = 1'b1;
    cyc(ACT - 3);
    ext_dom = 1'b0;
    cyc(8);
    check({5'h0, mode}, 8'(ST_PDOWN));
    ext_dom = 1'b1;
    wait_mode(ST_READY, ACT + 10);
    ext_dom = 1'b0;
    cs = 1'b1;
    wait_mode(ST_OPER, 10);
    cs = 1'b0;
    wait_mode(ST_PDOWN, 10);
    cs = 1'b1;
    wait_mode(ST_OPER, 20);
    $display("test activity done");
  endtask

  task automatic t_faults();
    therm = 1'b1;
    wait_mode(ST_TXOFF, 10);
    cyc(2);
    check({7'h0, ftx_oe}, 8'h01);
    check({6'h0, ftx_out, bus_out}, 8'h00);
    txd = 1'b0;
    cyc(5);
    check({7'h0, rxd}, 8'h01);
    txd = 1'b1;
    therm = 1'b0;
    cyc(6);
    check({5'h0, mode}, 8'(ST_TXOFF));
    trec = 1'b1;
    wait_mode(ST_OPER, 10);
    trec = 1'b0;
    host_ftx = 1'b1;
    wait_mode(ST_TXOFF, 10);
    host_ftx = 1'b0;
    wait_mode(ST_OPER, 10);
    txd = 1'b0;
    wait_mode(ST_TXOFF, TXD + 10);
    cyc(3);
    check({7'h0, bus_oe}, 8'h00);
    txd = 1'b1;
    wait_mode(ST_OPER, 10);
    ext_dom = 1'b1;
    wait_mode(ST_TXOFF, BUS + 10);
    cyc(2);
    check({6'h0, ftx_oe, rxd}, 8'h02);
    ext_dom = 1'b0;
    wait_mode(ST_OPER, 10);
    $display("test faults done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    bad_count = 0;
    checked = 0;
    rst = 1'b1;
    // host keeps select low until it is set up
    cs = 1'b0;
    txd = 1'b1;
    wake = 1'b1;
    therm = 1'b0;
    trec = 1'b0;
    sup = 1'b1;
    ext_dom = 1'b0;
    host_ftx = 1'b0;
    cs_rel = 1'b0;
    ext_sw = 1'b0;
    t_reset();
    t_select();
    t_wake();
    t_local_wake();
    t_activity();
    t_faults();
    give_verdict();
  end
endmodule
